// [dma_pkg.sv]
package dma_pkg;

  localparam int NCH = 4;

  // register offsets on the host port
  localparam logic [3:0] OFS_STATUS_CMD = 4'h8;
  localparam logic [3:0] OFS_REQUEST = 4'h9;
  localparam logic [3:0] OFS_CMDRD_SMASK = 4'hA;
  localparam logic [3:0] OFS_MODE = 4'hB;
  localparam logic [3:0] OFS_BYTE_PTR = 4'hC;
  localparam logic [3:0] OFS_TEMP_MCLR = 4'hD;
  localparam logic [3:0] OFS_MCNT_CLRMASK = 4'hE;
  localparam logic [3:0] OFS_ALL_MASK = 4'hF;

  // global_control bit positions
  localparam int CMD_ACK_POL = 7;
  localparam int CMD_REQ_POL = 6;
  localparam int CMD_EARLY_WR = 5;
  localparam int CMD_ROTATE = 4;
  localparam int CMD_COMPRESS = 3;
  localparam int CMD_DISABLE = 2;
  localparam int CMD_SRC_HOLD = 1;
  localparam int CMD_MEM2MEM = 0;

  // channel_mode field positions (stored as bits 7:2)
  localparam int MODE_TM_LSB = 6;
  localparam int MODE_DOWN = 5;
  localparam int MODE_AUTO = 4;
  localparam int MODE_TT_LSB = 2;

  // control field positions of request and single mask writes
  localparam int SEL_LSB = 0;
  localparam int SET_BIT = 2;

  localparam logic [1:0] TM_DEMAND = 2'h0;
  localparam logic [1:0] TM_SINGLE = 2'h1;
  localparam logic [1:0] TM_BLOCK = 2'h2;
  localparam logic [1:0] TM_CASCADE = 2'h3;
  localparam logic [1:0] TT_VERIFY = 2'h0;
  localparam logic [1:0] TT_WRITE = 2'h1;
  localparam logic [1:0] TT_READ = 2'h2;

  // values after reset, request readback fill and last count
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic [3:0] READ_ONES = 4'hF;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] CNT_LAST = 16'h0000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_HOLD = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_XFER = 6'b001000,
    ST_M2M_RD = 6'b010000,
    ST_M2M_WR = 6'b100000
  } state_t;

endpackage : dma_pkg

// [dma_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_arbiter (
  input wire logic [3:0] req,    // eligible channel requests
  input wire logic rotate,       // rotating priority select
  input wire logic [1:0] last,   // channel served last
  output logic valid,            // some channel requests
  output logic [1:0] grant       // winning channel
);
  logic [1:0] start;
  logic [1:0] idx;

  // fixed: channel 0 first; rotating: channel after the last served first
  assign start = rotate ? 2'(last + 2'h1) : 2'h0;
  assign valid = |req;

  always_comb begin
    grant = start;
    idx = start;
    for (int k = 3; k >= 0; k--) begin
      idx = 2'(start + 2'(k));
      if (req[idx]) begin
        grant = idx;
      end
    end
  end
endmodule : dma_arbiter
`default_nettype wire

// [dma_ctrl.sv]
// Functional notes
// - four 16-bit addresses, stepped, byte-wise host access
// - channel does programmed count plus one
// - count decrements; zero to FFFF flags terminal count
// - host address/count writes also load base
// - control register read/write, cleared by reset/clear
// - bit 7 acknowledge high, bit 6 request low
// - bit 5 asserts write strobes one state early
// - bit 4 selects rotating over fixed priority
// - bit 3 selects compressed transfer timing
// - bit 2 disables all DMA cycles
// - bit 0 mem-to-mem, bit 1 holds source
// - mode write: bits 1:0 pick channel
// - mode reads walk channels, bits 1:0 ones
// - mode bits 7:6 demand/single/block/cascade
// - mode bit 5 decrements, bit 4 autoinit
// - mode bits 3:2 verify/write/read type
// - request write sets/clears bit, mask ignored
// - request read: bits 3:0, upper ones, reset clears
// - single and all mask writes; mask blocks external
// - reset sets masks; clear command; terminal count masks unless autoinit
// - status: count-done flags and pending requests
// - temp byte captured then driven in mem-to-mem
// - byte pointer toggles per access, cleared by reset
// - mode reads start at channel 0 after clear
// - master clear acts like reset but keeps modes, addresses and counts, returns idle
// - one bus cycle, or two for mem-to-mem
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl (
  input wire logic ref_clk,                               // system clock
  input wire logic rst_b,                                 // async reset, active low
  input wire logic [3:0] addr,                            // register offset
  input wire logic [7:0] wdata,                           // write data
  input wire logic wr_stb,                                // write strobe
  input wire logic rd_stb,                                // read strobe
  output logic [7:0] rdata,                               // read data, cycle after strobe
  input wire logic [dma_pkg::NCH-1:0] request_line,       // peripheral requests, pins
  output logic [dma_pkg::NCH-1:0] acknowledge_line,       // peripheral acknowledges
  output logic hold_req,                                  // bus hold request
  input wire logic hold_ack,                              // bus hold granted, pin
  output logic [15:0] mem_addr,                           // transfer address
  input wire logic [7:0] data_in,                         // system data bus in
  output logic [7:0] data_out,                            // system data bus out
  output logic data_oe,                                   // data bus drive enable
  output logic mem_rd,                                    // memory read strobe
  output logic mem_wr,                                    // memory write strobe
  output logic io_rd,                                     // i/o read strobe
  output logic io_wr,                                     // i/o write strobe
  output logic term_count                                 // terminal count pulse
);
  import dma_pkg::*;

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction : put_byte

  function automatic logic [15:0] step(input logic [15:0] w, input logic down);
    step = down ? 16'(w - 16'h0001) : 16'(w + 16'h0001);
  endfunction : step

  logic [NCH-1:0] req_s1_q, req_s2_q;
  logic hack_s1_q, hack_s2_q;
  logic [7:0] cmd_q;
  logic [15:0] cur_addr_q [NCH];
  logic [15:0] cur_cnt_q [NCH];
  logic [15:0] base_addr_q [NCH];
  logic [15:0] base_cnt_q [NCH];
  logic [7:2] mode_q [NCH];
  logic [NCH-1:0] sreq_q, mask_q, tc_q;
  logic [7:0] temp_q, rdata_q, rd_val;
  logic ptr_q;
  logic [1:0] mcnt_q, ch_q, last_q;
  logic m2m_q;
  state_t st_q, st_d;

  // two-flop synchronisers for pins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_q <= '0;
      req_s2_q <= '0;
      hack_s1_q <= 1'b0;
      hack_s2_q <= 1'b0;
    end else begin
      req_s1_q <= request_line;
      req_s2_q <= req_s1_q;
      hack_s1_q <= hold_ack;
      hack_s2_q <= hack_s1_q;
    end
  end

  // host decode
  wire chan_acc = ~addr[3];
  wire [1:0] host_ch = addr[2:1];
  wire wr_cmd = wr_stb && addr == OFS_STATUS_CMD;
  wire wr_req = wr_stb && addr == OFS_REQUEST;
  wire wr_smask = wr_stb && addr == OFS_CMDRD_SMASK;
  wire wr_mode = wr_stb && addr == OFS_MODE;
  wire wr_ptr_clr = wr_stb && addr == OFS_BYTE_PTR;
  wire mclr = wr_stb && addr == OFS_TEMP_MCLR;
  wire wr_clrmask = wr_stb && addr == OFS_MCNT_CLRMASK;
  wire wr_amask = wr_stb && addr == OFS_ALL_MASK;
  wire rd_status = rd_stb && addr == OFS_STATUS_CMD;
  wire rd_mode = rd_stb && addr == OFS_MODE;
  wire rd_ptr_set = rd_stb && addr == OFS_BYTE_PTR;
  wire rd_mcnt_clr = rd_stb && addr == OFS_MCNT_CLRMASK;
  wire [1:0] wsel = wdata[SEL_LSB +: 2];

  // request qualification
  wire [NCH-1:0] ext_pend = cmd_q[CMD_REQ_POL] ? ~req_s2_q : req_s2_q;
  wire [NCH-1:0] eligible = (ext_pend & ~mask_q) | sreq_q;
  wire arb_valid;
  wire [1:0] arb_ch;

  dma_arbiter u_arb (
    .req(eligible),
    .rotate(cmd_q[CMD_ROTATE]),
    .last(last_q),
    .valid(arb_valid),
    .grant(arb_ch)
  );

  // active channel attributes
  wire [1:0] tm = mode_q[ch_q][MODE_TM_LSB +: 2];
  wire [1:0] tt = mode_q[ch_q][MODE_TT_LSB +: 2];
  wire cascade = tm == TM_CASCADE;
  wire dis = cmd_q[CMD_DISABLE];
  wire ew = cmd_q[CMD_EARLY_WR];
  wire ct = cmd_q[CMD_COMPRESS];
  wire [1:0] cc = m2m_q ? 2'h1 : ch_q;
  wire done = st_q == ST_XFER || st_q == ST_M2M_WR;
  wire tc_hit = done && cur_cnt_q[cc] == CNT_LAST;
  wire more = !tc_hit && !dis && (m2m_q || tm == TM_BLOCK ||
              (tm == TM_DEMAND && eligible[ch_q]));
  // a grant left over from the previous hold must drop before a new hold starts
  wire start = arb_valid && !dis && !hack_s2_q;
  wire m2m_go = cmd_q[CMD_MEM2MEM] && arb_ch == 2'h0;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hack_s2_q) begin
          if (cascade && !m2m_q) begin
            if (!eligible[ch_q]) begin
              st_d = ST_IDLE;
            end
          end else if (m2m_q) begin
            st_d = ST_M2M_RD;
          end else begin
            st_d = ct ? ST_XFER : ST_ADDR;
          end
        end
      end
      ST_ADDR: st_d = ST_XFER;
      ST_M2M_RD: st_d = ST_M2M_WR;
      ST_XFER, ST_M2M_WR: begin
        if (!more) begin
          st_d = ST_IDLE;
        end else if (m2m_q) begin
          st_d = ST_M2M_RD;
        end else begin
          st_d = ct ? ST_XFER : ST_ADDR;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      ch_q <= 2'h0;
      m2m_q <= 1'b0;
      last_q <= 2'h3;
    end else if (mclr) begin
      st_q <= ST_IDLE;
      ch_q <= 2'h0;
      m2m_q <= 1'b0;
      last_q <= 2'h3;
    end else begin
      st_q <= st_d;
      if (st_q == ST_IDLE && start) begin
        ch_q <= arb_ch;
        m2m_q <= m2m_go;
        last_q <= arb_ch;
      end
    end
  end

  // per-channel address and count stepping
  logic [NCH-1:0] adv_a, adv_c, reload, hw_a, hw_c;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      hw_a[i] = wr_stb && chan_acc && host_ch == 2'(i) && !addr[0];
      hw_c[i] = wr_stb && chan_acc && host_ch == 2'(i) && addr[0];
      adv_c[i] = done && cc == 2'(i);
      adv_a[i] = done && (m2m_q ? (i == 1 || (i == 0 && !cmd_q[CMD_SRC_HOLD]))
                               : ch_q == 2'(i));
      reload[i] = tc_hit && cc == 2'(i) && mode_q[i][MODE_AUTO];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCH; i++) begin
        cur_addr_q[i] <= WORD_RST;
        cur_cnt_q[i] <= WORD_RST;
        base_addr_q[i] <= WORD_RST;
        base_cnt_q[i] <= WORD_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (hw_a[i]) begin
          cur_addr_q[i] <= put_byte(cur_addr_q[i], ptr_q, wdata);
          base_addr_q[i] <= put_byte(base_addr_q[i], ptr_q, wdata);
        end else if (reload[i]) begin
          cur_addr_q[i] <= base_addr_q[i];
        end else if (adv_a[i]) begin
          cur_addr_q[i] <= step(cur_addr_q[i], mode_q[i][MODE_DOWN]);
        end
        if (hw_c[i]) begin
          cur_cnt_q[i] <= put_byte(cur_cnt_q[i], ptr_q, wdata);
          base_cnt_q[i] <= put_byte(base_cnt_q[i], ptr_q, wdata);
        end else if (reload[i]) begin
          cur_cnt_q[i] <= base_cnt_q[i];
        end else if (adv_c[i]) begin
          cur_cnt_q[i] <= step(cur_cnt_q[i], 1'b1);
        end
      end
    end
  end

  // global control
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= CMD_RST;
    end else if (mclr) begin
      cmd_q <= CMD_RST;
    end else if (wr_cmd) begin
      cmd_q <= wdata;
    end
  end

  // channel modes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCH; i++) begin
        mode_q[i] <= 6'h00;
      end
    end else if (wr_mode) begin
      mode_q[wsel] <= wdata[7:2];
    end
  end

  // software requests, masks and count-done flags; hardware set wins
  logic [NCH-1:0] tc_set, tc_srv, sreq_d, mask_d, tc_d;
  always_comb begin
    tc_set = '0;
    tc_set[cc] = tc_hit;
    tc_srv = '0;
    tc_srv[ch_q] = tc_hit;
    // the served channel drops its request too, so a copy does not restart
    sreq_d = sreq_q & ~tc_set & ~tc_srv;
    if (wr_req) begin
      sreq_d[wsel] = wdata[SET_BIT];
    end
    mask_d = mask_q;
    if (wr_smask) begin
      mask_d[wsel] = wdata[SET_BIT];
    end
    if (wr_amask) begin
      mask_d = wdata[3:0];
    end
    if (wr_clrmask) begin
      mask_d = '0;
    end
    mask_d = mask_d | (tc_set & ~(reload));
    tc_d = (rd_status ? '0 : tc_q) | tc_set;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sreq_q <= '0;
      mask_q <= MASK_RST;
      tc_q <= '0;
    end else if (mclr) begin
      sreq_q <= '0;
      mask_q <= MASK_RST;
      tc_q <= '0;
    end else begin
      sreq_q <= sreq_d;
      mask_q <= mask_d;
      tc_q <= tc_d;
    end
  end

  // holding byte for memory-to-memory
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_q <= 8'h00;
    end else if (mclr) begin
      temp_q <= 8'h00;
    end else if (st_q == ST_M2M_RD) begin
      temp_q <= data_in;
    end
  end

  // byte pointer and mode read counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= 1'b0;
      mcnt_q <= 2'h0;
    end else if (mclr) begin
      ptr_q <= 1'b0;
      mcnt_q <= 2'h0;
    end else begin
      if (wr_ptr_clr) begin
        ptr_q <= 1'b0;
      end else if (rd_ptr_set) begin
        ptr_q <= 1'b1;
      end else if ((rd_stb || wr_stb) && chan_acc) begin
        ptr_q <= ~ptr_q;
      end
      if (rd_mcnt_clr) begin
        mcnt_q <= 2'h0;
      end else if (rd_mode) begin
        mcnt_q <= 2'(mcnt_q + 2'h1);
      end
    end
  end

  // read data mux
  wire [15:0] rd_word = addr[0] ? cur_cnt_q[host_ch] : cur_addr_q[host_ch];
  always_comb begin
    rd_val = 8'h00;
    if (chan_acc) begin
      rd_val = ptr_q ? rd_word[15:8] : rd_word[7:0];
    end else begin
      unique case (addr)
        OFS_STATUS_CMD: rd_val = {ext_pend, tc_q};
        OFS_REQUEST: rd_val = {READ_ONES, sreq_q};
        OFS_CMDRD_SMASK: rd_val = cmd_q;
        OFS_MODE: rd_val = {mode_q[mcnt_q], 2'b11};
        OFS_TEMP_MCLR: rd_val = temp_q;
        OFS_ALL_MASK: rd_val = {4'h0, mask_q};
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_stb ? rd_val : 8'h00;
    end
  end
  assign rdata = rdata_q;

  // transfer outputs
  wire ack_act = (st_q == ST_HOLD && hack_s2_q && cascade && !m2m_q) ||
                 st_q == ST_ADDR || (st_q == ST_XFER && !m2m_q);
  wire [NCH-1:0] ack_vec = ack_act ? NCH'(1) << ch_q : '0;
  wire wr_ph = st_q == ST_XFER || (ew && st_q == ST_ADDR);
  assign acknowledge_line = cmd_q[CMD_ACK_POL] ? ack_vec : ~ack_vec;
  assign hold_req = st_q != ST_IDLE;
  assign mem_addr = st_q == ST_M2M_WR ? cur_addr_q[1] :
                    (m2m_q ? cur_addr_q[0] : cur_addr_q[ch_q]);
  assign mem_rd = (st_q == ST_XFER && tt == TT_READ) || st_q == ST_M2M_RD;
  assign io_rd = st_q == ST_XFER && tt == TT_WRITE;
  assign mem_wr = (wr_ph && !m2m_q && tt == TT_WRITE) || st_q == ST_M2M_WR ||
                  (ew && st_q == ST_M2M_RD);
  assign io_wr = wr_ph && !m2m_q && tt == TT_READ;
  assign data_out = temp_q;
  assign data_oe = st_q == ST_M2M_WR;
  assign term_count = tc_hit;
endmodule : dma_ctrl
`default_nettype wire

// [dma_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_properties (
  input wire logic ref_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [3:0] addr, // register offset
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  input wire logic [7:0] rdata, // read data
  input wire logic [dma_pkg::NCH-1:0] acknowledge_line, // acknowledges
  input wire logic hold_req, // bus hold request
  input wire logic [7:0] data_in, // system data bus in
  input wire logic [7:0] data_out, // holding byte out
  input wire logic data_oe, // data bus drive enable
  input wire logic mem_rd, // memory read strobe
  input wire logic mem_wr, // memory write strobe
  input wire logic io_rd, // i/o read strobe
  input wire logic io_wr, // i/o write strobe
  input wire logic term_count // terminal count pulse
);
  import dma_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic any_stb = mem_rd | mem_wr | io_rd | io_wr;
  sequence s_m2m_read;
    mem_rd && !io_wr && !io_rd;
  endsequence
  sequence s_m2m_write;
    data_oe && mem_wr;
  endsequence
  property p_req_ones;
    rd_stb && addr == OFS_REQUEST |=> rdata[7:4] == READ_ONES;
  endproperty
  property p_mode_ones;
    rd_stb && addr == OFS_MODE |=> rdata[1:0] == 2'b11;
  endproperty
  property p_mask_upper;
    rd_stb && addr == OFS_ALL_MASK |=> rdata[7:4] == 4'h0;
  endproperty
  property p_strobe_in_hold;
    any_stb |-> hold_req;
  endproperty
  property p_hold_settle;
    $rose(hold_req) |-> !any_stb [*2];
  endproperty
  property p_m2m_pair;
    s_m2m_write |-> $past(mem_rd) && !$past(data_oe);
  endproperty
  property p_temp_capture;
    s_m2m_read ##1 s_m2m_write |-> data_out == $past(data_in);
  endproperty
  property p_temp_hold;
    !(mem_rd && !io_wr) && !(wr_stb && addr == OFS_TEMP_MCLR) |=> $stable(data_out);
  endproperty
  property p_tc_pulse;
    term_count |=> !term_count;
  endproperty
  property p_ack_idle;
    !hold_req |-> acknowledge_line inside {4'h0, 4'hF};
  endproperty
  a_req_ones: assert property (p_req_ones) else $error("request readback upper bits wrong");
  a_mode_ones: assert property (p_mode_ones) else $error("mode readback low bits wrong");
  a_mask_upper: assert property (p_mask_upper) else $error("mask readback upper bits wrong");
  a_strobe_in_hold: assert property (p_strobe_in_hold) else $error("strobe outside hold");
  a_hold_settle: assert property (p_hold_settle) else $error("strobe before grant");
  a_m2m_pair: assert property (p_m2m_pair) else $error("copy write without read");
  a_temp_capture: assert property (p_temp_capture) else $error("holding byte wrong");
  a_temp_hold: assert property (p_temp_hold) else $error("holding byte changed");
  a_tc_pulse: assert property (p_tc_pulse) else $error("terminal count too long");
  a_ack_idle: assert property (p_ack_idle) else $error("acknowledge active while idle");
endmodule : dma_ctrl_properties
`default_nettype wire

// [dma_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_partner (
  input wire logic ref_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic hold_req, // hold request from controller
  input wire logic mem_rd, // memory read strobe
  input wire logic [3:0] grant_delay, // cycles before the bus is granted
  input wire logic [3:0] req_want, // peripherals wanting service
  input wire logic req_low, // request pins active low
  input wire logic [7:0] mem_byte, // byte that memory returns
  output logic hold_ack, // bus grant
  output logic [3:0] request_line, // request pins
  output logic [7:0] data_in // system data bus
);
  logic [3:0] wait_q;
  logic [7:0] noise_q;
  assign request_line = req_low ? ~req_want : req_want;
  // the bus floats outside memory reads, so it shows a changing pattern
  assign data_in = mem_rd ? mem_byte : noise_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_ack <= 1'b0;
      wait_q <= 4'h0;
      noise_q <= 8'h5A;
    end else begin
      noise_q <= ~noise_q;
      if (!hold_req) begin
        hold_ack <= 1'b0;
        wait_q <= 4'h0;
      end else if (wait_q == grant_delay) begin
        hold_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : dma_partner
`default_nettype wire

// [tb_dma_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dma_ctrl;
  import dma_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [3:0] grant_delay = 4'h0;
  logic [3:0] req_want = 4'h0;
  logic req_low = 1'b0;
  logic [7:0] mem_byte = 8'h00;
  wire logic [7:0] rdata, data_in, data_out;
  wire logic [3:0] request_line, acknowledge_line;
  wire logic [15:0] mem_addr;
  wire logic hold_req, hold_ack, data_oe, mem_rd, mem_wr, io_rd, io_wr, term_count;
  logic [23:0] seen_q[$];
  int tc_seen = 0;
  int cycles = 0;
  int miscompares = 0;
  int samples_checked = 0;
  always #50 ref_clk = ~ref_clk;
  dma_ctrl dma_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .request_line(request_line),
    .acknowledge_line(acknowledge_line), .hold_req(hold_req), .hold_ack(hold_ack),
    .mem_addr(mem_addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .io_rd(io_rd), .io_wr(io_wr), .term_count(term_count));
  dma_partner dma_partner_inst (.ref_clk(ref_clk), .rst_b(rst_b), .hold_req(hold_req),
    .mem_rd(mem_rd), .grant_delay(grant_delay), .req_want(req_want), .req_low(req_low),
    .mem_byte(mem_byte), .hold_ack(hold_ack), .request_line(request_line), .data_in(data_in));
  // records every strobe cycle as {strobes, acknowledges, address}
  always @(posedge ref_clk) begin
    if (rst_b && (mem_rd || mem_wr || io_rd || io_wr))
      seen_q.push_back({mem_rd, mem_wr, io_rd, io_wr, acknowledge_line, mem_addr});
    if (rst_b && term_count === 1'b1) tc_seen++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e, input bit c = 1'b1);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    if (c) check({16'h0, rdata}, {16'h0, e});
  endtask : rd
  task wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask : wr16
  task rd16(input logic [3:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a, e[15:8]);
  endtask : rd16
  task pop(input logic [23:0] e);
    check(seen_q.size() > 0 ? seen_q.pop_front() : 24'h0, e);
  endtask : pop
  // waits for the cumulative count of terminal counts and the bus released
  task wait_tc(input int n);
    int k;
    k = 0;
    while ((tc_seen < n || hold_req !== 1'b0) && k < 400) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check(24'(tc_seen), 24'(n));
  endtask : wait_tc
  task sc_reset_values;
    rd(OFS_STATUS_CMD, 8'h00);
    rd(OFS_CMDRD_SMASK, CMD_RST);
    rd(OFS_REQUEST, 8'hF0);
    rd(OFS_ALL_MASK, {4'h0, MASK_RST});
  endtask : sc_reset_values
  task sc_byte_pointer;
    wr(OFS_BYTE_PTR, 8'h00);
    wr16(4'h6, 16'hBEEF);
    wr(4'h7, 8'h34);
    rd(4'h6, 8'hBE);
    wr(OFS_BYTE_PTR, 8'h00);
    rd16(4'h6, 16'hBEEF);
    rd(OFS_BYTE_PTR, 8'h00, 1'b0);
    rd(4'h7, WORD_RST[15:8]);
  endtask : sc_byte_pointer
  task sc_modes;
    logic [7:0] m[4];
    for (int i = 0; i < 4; i++) begin
      m[i] = {i[1:0], i[0], i[1], (i == 3) ? TT_READ : i[1:0], i[1:0]};
      wr(OFS_MODE, m[i]);
    end
    rd(OFS_MCNT_CLRMASK, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) rd(OFS_MODE, {m[i][7:2], 2'b11});
  endtask : sc_modes
  task sc_single;
    wr(OFS_STATUS_CMD, 8'hC0);
    req_low <= 1'b1;
    wr(OFS_MODE, 8'h45);
    wr(OFS_BYTE_PTR, 8'h00);
    wr16(4'h2, 16'h1000);
    wr16(4'h3, 16'h0001);
    rd16(4'h3, 16'h0001);
    wr(OFS_CMDRD_SMASK, 8'h01);
    req_want <= 4'h2;
    wait_tc(1);
    pop({4'b0110, 4'h2, 16'h1000});
    pop({4'b0110, 4'h2, 16'h1001});
    rd(OFS_STATUS_CMD, 8'h22);
    rd(OFS_STATUS_CMD, 8'h20);
    rd(OFS_ALL_MASK, 8'h0F);
    rd16(4'h3, 16'hFFFF);
    rd16(4'h2, 16'h1002);
    pop(24'h0);
    req_want <= 4'h0;
    rd(OFS_STATUS_CMD, 8'h00, 1'b0);
    rd(OFS_STATUS_CMD, 8'h00);
  endtask : sc_single
  task sc_sw_priority;
    req_low <= 1'b0;
    wr(OFS_STATUS_CMD, 8'h04);
    wr(OFS_MODE, 8'h4A);
    wr(OFS_MODE, 8'h4B);
    wr16(4'h4, 16'h4000);
    wr16(4'h5, 16'h0000);
    wr16(4'h6, 16'h5000);
    wr16(4'h7, 16'h0000);
    wr(OFS_REQUEST, 8'h07);
    wr(OFS_REQUEST, 8'h06);
    rd(OFS_REQUEST, 8'hFC);
    grant_delay <= 4'h5;
    repeat (10) @(posedge ref_clk);
    check({23'h0, hold_req}, 24'h0);
    wr(OFS_STATUS_CMD, 8'h20);
    wait_tc(3);
    pop({4'b0001, 4'hB, 16'h4000});
    pop({4'b1001, 4'hB, 16'h4000});
    pop({4'b0001, 4'h7, 16'h5000});
    pop({4'b1001, 4'h7, 16'h5000});
    rd(OFS_REQUEST, 8'hF0);
    rd(OFS_STATUS_CMD, 8'h0C);
    wr(OFS_MCNT_CLRMASK, 8'h00);
    rd(OFS_ALL_MASK, 8'h00);
  endtask : sc_sw_priority
  task sc_mem2mem;
    mem_byte <= 8'hA5;
    grant_delay <= 4'h0;
    wr(OFS_STATUS_CMD, 8'h01);
    wr(OFS_MODE, 8'h80);
    wr(OFS_MODE, 8'h81);
    wr16(4'h0, 16'h2000);
    wr16(4'h2, 16'h3000);
    wr16(4'h3, 16'h0000);
    wr(OFS_REQUEST, 8'h04);
    wait_tc(4);
    pop({4'b1000, 4'hF, 16'h2000});
    pop({4'b0100, 4'hF, 16'h3000});
    rd(OFS_TEMP_MCLR, 8'hA5);
    wr(OFS_TEMP_MCLR, 8'h00);
    rd(OFS_TEMP_MCLR, 8'h00);
    rd(OFS_CMDRD_SMASK, 8'h00);
    rd(OFS_ALL_MASK, 8'h0F);
    pop(24'h0);
  endtask : sc_mem2mem
  task sc_rotate;
    wr(OFS_STATUS_CMD, 8'h1C);
    wr(OFS_MODE, 8'h64);
    wr(OFS_MODE, 8'h45);
    wr16(4'h0, 16'h0100);
    wr16(4'h1, 16'h0001);
    wr16(4'h2, 16'h0200);
    wr16(4'h3, 16'h0001);
    wr(OFS_REQUEST, 8'h04);
    wr(OFS_REQUEST, 8'h05);
    wr(OFS_STATUS_CMD, 8'h18);
    wait_tc(6);
    pop({4'b0110, 4'hE, 16'h0100});
    pop({4'b0110, 4'hD, 16'h0200});
    pop({4'b0110, 4'hE, 16'h00FF});
    pop({4'b0110, 4'hD, 16'h0201});
    rd16(4'h0, 16'h00FE);
    rd(OFS_STATUS_CMD, 8'h03);
    pop(24'h0);
  endtask : sc_rotate
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    sc_reset_values();
    sc_byte_pointer();
    sc_modes();
    sc_single();
    sc_sw_priority();
    sc_mem2mem();
    sc_rotate();
    summarize();
  end
endmodule : tb_dma_ctrl
bind dma_ctrl dma_ctrl_properties dma_ctrl_properties_inst (.ref_clk(ref_clk), .rst_b(rst_b),
  .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .acknowledge_line(acknowledge_line), .hold_req(hold_req), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .mem_rd(mem_rd), .mem_wr(mem_wr), .io_rd(io_rd),
  .io_wr(io_wr), .term_count(term_count));
`default_nettype wire
